// ### verilog/pcw_pkg.sv
// Shared constants, register map and mode decoding for the compare array.
// Assumes an APB slave top with five compare modules and one shared counter.
package pcw_pkg;

  // Number of compare modules and the one that may act as a watchdog.
  localparam int NUM_MOD = 5;
  localparam int WDT_MOD = 4;

  // Register byte addresses; per-module banks step by one word.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PCA_MODE = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MODE_BASE = 8'h20;
  localparam logic [7:0] ADDR_CMPL_BASE = 8'h40;
  localparam logic [7:0] ADDR_CMPH_BASE = 8'h60;
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // Bit positions inside module_mode_register.
  localparam int MB_IRQ_EN = 0;
  localparam int MB_PWM = 1;
  localparam int MB_FLIP = 2;
  localparam int MB_EQ_EV = 3;
  localparam int MB_CMP_EN = 6;

  // Bit positions inside pca_mode_register and pca_control_register.
  localparam int CM_SRC_LO = 1;
  localparam int CM_WDOG_EN = 6;
  localparam int CC_RUN = 6;

  // Values after reset.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [6:0] RST_MODE = 7'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;

  // Prescaler counts for the two divided clock sources.
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;

  // Counter clock sources, held in pca_mode_register bits 2:1.
  typedef enum logic [1:0] {
    SRC_DIV12,
    SRC_DIV4,
    SRC_T0OVF,
    SRC_EXT
  } pcw_src_t;

  // Compare with match event: software timer, high-speed output, watchdog.
  function automatic logic mode_is_match(input logic [6:0] m);
    return m[MB_CMP_EN] & m[MB_EQ_EV] & ~m[MB_PWM];
  endfunction

  // High-speed output: the match also flips the pin.
  function automatic logic mode_is_hso(input logic [6:0] m);
    return mode_is_match(m) & m[MB_FLIP];
  endfunction

  // Eight-bit pulse width modulation.
  function automatic logic mode_is_pwm(input logic [6:0] m);
    return m[MB_CMP_EN] & m[MB_PWM] & ~m[MB_EQ_EV];
  endfunction

endpackage

// ### verilog/pcw_timebase.sv
// Clock-event generator for the shared counter.
// Assumes t0_ovf is a one-cycle pulse on the core clock and ext_pin is
// asynchronous to it.
module pcw_timebase
  import pcw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] src,
  input wire logic t0_ovf,
  input wire logic ext_pin,
  output logic tick
);

  logic [3:0] pre_r;
  logic [3:0] pre_nxt;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic ext_lvl_r;
  logic ext_lvl_nxt;
  logic tick_r;
  logic tick_nxt;
  logic ext_stable;
  logic ext_rise;

  // A pin change counts only when the second and third stages agree.
  assign ext_stable = (sync_r[1] == sync_r[2]);
  assign ext_rise = ext_stable & sync_r[2] & ~ext_lvl_r;
  assign tick = tick_r;

  // Prescaler and source select; a stopped counter also clears the divider.
  always_comb begin
    pre_nxt = pre_r;
    tick_nxt = 1'b0;
    sync_nxt = {sync_r[1:0], ext_pin};
    ext_lvl_nxt = ext_stable ? sync_r[2] : ext_lvl_r;
    if (!run) begin
      pre_nxt = 4'h0;
    end else begin
      case (pcw_src_t'(src))
        SRC_DIV12, SRC_DIV4: begin
          if (pre_r == ((src == 2'(SRC_DIV12)) ? DIV_SLOW : DIV_FAST) - 4'h1)
          begin
            pre_nxt = 4'h0;
            tick_nxt = 1'b1;
          end else begin
            pre_nxt = pre_r + 4'h1;
          end
        end
        SRC_T0OVF: tick_nxt = t0_ovf;
        SRC_EXT: tick_nxt = ext_rise;
        default: tick_nxt = 1'b0;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_r <= 4'h0;
      sync_r <= 3'h0;
      ext_lvl_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      sync_r <= sync_nxt;
      ext_lvl_r <= ext_lvl_nxt;
      tick_r <= tick_nxt;
    end
  end

endmodule

// ### verilog/pcw_cmp_unit.sv
// One compare module: match detection and the output pin it drives.
// Assumes step pulses for one cycle after each counter increment.
module pcw_cmp_unit
  import pcw_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [6:0] mode,
  input wire logic [15:0] cnt,
  input wire logic step,
  input wire logic armed,
  input wire logic [15:0] cmp_val,
  output logic match,
  output logic pin,
  output logic oe_n
);

  logic pin_r;
  logic pin_nxt;

  // The full 16-bit compare is checked once per count, and never while
  // the value is half written.
  assign match = step & armed & mode_is_match(mode) & (cnt == cmp_val);
  assign pin = pin_r;
  assign oe_n = ~(mode_is_hso(mode) | mode_is_pwm(mode));

  // Pin level: flipped at a match, or compared on the low bytes for PWM.
  always_comb begin
    pin_nxt = pin_r;
    if (mode_is_hso(mode) && match) begin
      pin_nxt = ~pin_r;
    end else if (mode_is_pwm(mode)) begin
      pin_nxt = (cnt[7:0] >= cmp_val[7:0]);
    end
  end

  // Pin register.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

endmodule

// ### verilog/pcw_top.sv
// Compare-side counter array: shared counter, five compare modules,
// register file on APB and the module-4 watchdog reset request.
// Assumes an APB3 master on CORE_CLK, and that WDT_RST_REQ is routed to
// the internal reset tree only.
//
// Functional notes
// - compare_enable plus equal_event_enable gives software timer.
// - match sets flag; interrupt needs flag and enable.
// - low-byte write suspends comparator; high-byte resumes.
// - flip, equal-event and compare enables give high-speed output.
// - high-speed output inverts pin at every full match.
// - pin inversion is hardware, independent of interrupt.
// - unchanged compare value toggles again after wrap.
// - pwm_select plus compare_enable gives 8-bit PWM.
// - pin low below low compare, high otherwise.
// - high byte copied to low at low-byte wrap.
// - all modules share one counter time base.
// - counter source is osc/12, osc/4, timer0, external.
// - watchdog only on module 4; otherwise normal.
// - module 4 match makes internal reset only.
// - watchdog needs compare mode and reset_on_match_enable.
// - clearing reset_on_match_enable before match prevents reset.
module pcw_top
  import pcw_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic T0_OVF,
  input wire logic EXT_CLK_IN,
  output logic [NUM_MOD-1:0] MODULE_IO_OUT,
  output logic [NUM_MOD-1:0] MODULE_IO_OE_N,
  output logic IRQ,
  output logic WDT_RST_REQ
);

  // Bank slot of an address inside a five-word bank, or SLOT_NONE.
  function automatic logic [2:0] slot_of(input logic [7:0] a,
                                         input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    if (a >= base && off < 8'(NUM_MOD * 4) && off[1:0] == 2'b00) begin
      return off[4:2];
    end
    return SLOT_NONE;
  endfunction

  // True for every address that holds a register.
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_PCA_MODE) || (a == ADDR_CNT_LO) ||
           (a == ADDR_CNT_HI) || (a == ADDR_STATUS) ||
           (slot_of(a, ADDR_MODE_BASE) != SLOT_NONE) ||
           (slot_of(a, ADDR_CMPL_BASE) != SLOT_NONE) ||
           (slot_of(a, ADDR_CMPH_BASE) != SLOT_NONE);
  endfunction

  // Control and counter state.
  logic run_r;
  logic run_nxt;
  logic wdog_en_r;
  logic wdog_en_nxt;
  logic [1:0] src_r;
  logic [1:0] src_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic upd_r;
  logic upd_nxt;
  logic [NUM_MOD-1:0] flags_r;
  logic [NUM_MOD-1:0] flags_nxt;

  // Per-module state.
  logic [NUM_MOD-1:0][6:0] mode_r;
  logic [NUM_MOD-1:0][6:0] mode_nxt;
  logic [NUM_MOD-1:0][7:0] cmp_lo_r;
  logic [NUM_MOD-1:0][7:0] cmp_lo_nxt;
  logic [NUM_MOD-1:0][7:0] cmp_hi_r;
  logic [NUM_MOD-1:0][7:0] cmp_hi_nxt;
  logic [NUM_MOD-1:0] armed_r;
  logic [NUM_MOD-1:0] armed_nxt;

  // Output registers.
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wdt_r;
  logic wdt_nxt;

  // Bus decode and events.
  logic wr_en;
  logic rd_setup;
  logic [2:0] wr_mode_slot;
  logic [2:0] wr_lo_slot;
  logic [2:0] wr_hi_slot;
  logic [2:0] rd_mode_slot;
  logic [2:0] rd_lo_slot;
  logic [2:0] rd_hi_slot;
  logic tick;
  logic lo_wrap;
  logic [NUM_MOD-1:0] match;
  logic [NUM_MOD-1:0] irq_en_vec;

  // The slave never inserts wait states; unmapped accesses answer with
  // an error and change nothing.
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~is_mapped(PADDR);
  assign PRDATA = rdata_r;
  assign IRQ = irq_r;
  assign WDT_RST_REQ = wdt_r;

  assign wr_en = PSEL & PENABLE & PWRITE;
  assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
  assign wr_mode_slot = wr_en ? slot_of(PADDR, ADDR_MODE_BASE) : SLOT_NONE;
  assign wr_lo_slot = wr_en ? slot_of(PADDR, ADDR_CMPL_BASE) : SLOT_NONE;
  assign wr_hi_slot = wr_en ? slot_of(PADDR, ADDR_CMPH_BASE) : SLOT_NONE;
  assign rd_mode_slot = slot_of(PADDR, ADDR_MODE_BASE);
  assign rd_lo_slot = slot_of(PADDR, ADDR_CMPL_BASE);
  assign rd_hi_slot = slot_of(PADDR, ADDR_CMPH_BASE);

  // The low byte has just rolled from 255 to 0 when a count lands on 00.
  assign lo_wrap = upd_r & (cnt_r[7:0] == 8'h00);

  // Counter clock events from the selected source.
  pcw_timebase u_timebase (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .run(run_r),
    .src(src_r),
    .t0_ovf(T0_OVF),
    .ext_pin(EXT_CLK_IN),
    .tick(tick)
  );

  // Every module compares against the same counter, so all PWM outputs
  // share one frequency.
  for (genvar i = 0; i < NUM_MOD; i++) begin : g_mod
    assign irq_en_vec[i] = mode_r[i][MB_IRQ_EN];
    pcw_cmp_unit u_cmp (
      .clk(CORE_CLK),
      .rst(SYS_RST),
      .mode(mode_r[i]),
      .cnt(cnt_r),
      .step(upd_r),
      .armed(armed_r[i]),
      .cmp_val({cmp_hi_r[i], cmp_lo_r[i]}),
      .match(match[i]),
      .pin(MODULE_IO_OUT[i]),
      .oe_n(MODULE_IO_OE_N[i])
    );
  end

  // Counter, control bits and event flags. A bus write to the counter
  // wins over a count in the same cycle; a match wins over a flag clear.
  always_comb begin
    run_nxt = run_r;
    wdog_en_nxt = wdog_en_r;
    src_nxt = src_r;
    cnt_nxt = cnt_r;
    upd_nxt = tick;
    if (tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    flags_nxt = flags_r;
    if (wr_en && PADDR == ADDR_CTRL) begin
      flags_nxt = PWDATA[NUM_MOD-1:0];
      run_nxt = PWDATA[CC_RUN];
    end
    if (wr_en && PADDR == ADDR_PCA_MODE) begin
      wdog_en_nxt = PWDATA[CM_WDOG_EN];
      src_nxt = PWDATA[CM_SRC_LO+1:CM_SRC_LO];
    end
    if (wr_en && PADDR == ADDR_CNT_LO) begin
      cnt_nxt[7:0] = PWDATA[7:0];
    end
    if (wr_en && PADDR == ADDR_CNT_HI) begin
      cnt_nxt[15:8] = PWDATA[7:0];
    end
    flags_nxt = flags_nxt | match;
  end

  // Per-module registers. The comparator is suspended from a low-byte
  // write until the matching high-byte write, so a half-updated value
  // cannot match.
  always_comb begin
    mode_nxt = mode_r;
    cmp_lo_nxt = cmp_lo_r;
    cmp_hi_nxt = cmp_hi_r;
    armed_nxt = armed_r;
    for (int i = 0; i < NUM_MOD; i++) begin
      if (wr_mode_slot == 3'(i)) begin
        mode_nxt[i] = PWDATA[6:0];
      end
      if (wr_lo_slot == 3'(i)) begin
        cmp_lo_nxt[i] = PWDATA[7:0];
        armed_nxt[i] = 1'b0;
      end
      if (wr_hi_slot == 3'(i)) begin
        cmp_hi_nxt[i] = PWDATA[7:0];
        armed_nxt[i] = 1'b1;
      end
      // The duty byte reaches the comparator only at a period boundary,
      // which keeps a write from cutting a pulse short.
      if (mode_is_pwm(mode_r[i]) && lo_wrap) begin
        cmp_lo_nxt[i] = cmp_hi_r[i];
      end
    end
  end

  // Interrupt request and watchdog reset request. The watchdog drives
  // only the internal reset request, never the external reset pin.
  always_comb begin
    irq_nxt = |(flags_r & irq_en_vec);
    wdt_nxt = match[WDT_MOD] & wdog_en_r &
              mode_is_match(mode_r[WDT_MOD]);
  end

  // Read data are captured in the setup phase, so they stand for the
  // whole access phase.
  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_setup) begin
      rdata_nxt = 32'h0000_0000;
      if (PADDR == ADDR_CTRL) begin
        rdata_nxt[NUM_MOD-1:0] = flags_r;
        rdata_nxt[CC_RUN] = run_r;
      end else if (PADDR == ADDR_PCA_MODE) begin
        rdata_nxt[CM_WDOG_EN] = wdog_en_r;
        rdata_nxt[CM_SRC_LO+1:CM_SRC_LO] = src_r;
      end else if (PADDR == ADDR_CNT_LO) begin
        rdata_nxt[7:0] = cnt_r[7:0];
      end else if (PADDR == ADDR_CNT_HI) begin
        rdata_nxt[7:0] = cnt_r[15:8];
      end else if (PADDR == ADDR_STATUS) begin
        rdata_nxt[NUM_MOD-1:0] = MODULE_IO_OUT;
        rdata_nxt[8+NUM_MOD-1:8] = armed_r;
      end else begin
        for (int i = 0; i < NUM_MOD; i++) begin
          if (rd_mode_slot == 3'(i)) begin
            rdata_nxt[6:0] = mode_r[i];
          end
          if (rd_lo_slot == 3'(i)) begin
            rdata_nxt[7:0] = cmp_lo_r[i];
          end
          if (rd_hi_slot == 3'(i)) begin
            rdata_nxt[7:0] = cmp_hi_r[i];
          end
        end
      end
    end
  end

  // Control and counter registers.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      run_r <= 1'b0;
      wdog_en_r <= 1'b0;
      src_r <= 2'(SRC_DIV12);
      cnt_r <= RST_CNT;
      upd_r <= 1'b0;
      flags_r <= '0;
    end else begin
      run_r <= run_nxt;
      wdog_en_r <= wdog_en_nxt;
      src_r <= src_nxt;
      cnt_r <= cnt_nxt;
      upd_r <= upd_nxt;
      flags_r <= flags_nxt;
    end
  end

  // Per-module registers. Comparators start armed so a mode set with
  // the reset compare value still matches.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NUM_MOD; i++) begin
        mode_r[i] <= RST_MODE;
        cmp_lo_r[i] <= RST_BYTE;
        cmp_hi_r[i] <= RST_BYTE;
      end
      armed_r <= '1;
    end else begin
      mode_r <= mode_nxt;
      cmp_lo_r <= cmp_lo_nxt;
      cmp_hi_r <= cmp_hi_nxt;
      armed_r <= armed_nxt;
    end
  end

  // Output registers.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
      irq_r <= 1'b0;
      wdt_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      wdt_r <= wdt_nxt;
    end
  end

endmodule

// ### test/pcw_chk.sv
// Checker for the compare array top: bus answers, reset state, pulses.
// Assumes it is bound to pcw_top and sees only that module's ports.
module pcw_chk
  import pcw_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic T0_OVF,
  input wire logic EXT_CLK_IN,
  input wire logic [NUM_MOD-1:0] MODULE_IO_OUT,
  input wire logic [NUM_MOD-1:0] MODULE_IO_OE_N,
  input wire logic IRQ,
  input wire logic WDT_RST_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic acc;
  assign acc = PSEL & PENABLE;

  // Bus answers: no wait states, errors only on holes in the map.
  property p_ready; acc |-> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("access without ready");
  property p_err_idle; !acc |-> !PSLVERR; endproperty
  a_err_idle: assert property (p_err_idle) else $error("error outside access");
  property p_err_hole;
    acc && PADDR > 8'h70 |-> PSLVERR && (PWRITE || PRDATA == 32'h0);
  endproperty
  a_err_hole: assert property (p_err_hole) else $error("hole not refused");
  property p_err_ctrl; acc && PADDR == ADDR_CTRL |-> !PSLVERR; endproperty
  a_err_ctrl: assert property (p_err_ctrl) else $error("control refused");
  property p_rsv; acc && !PWRITE |-> PRDATA[31:16] == 16'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("upper read bits set");
  // Outputs leave reset quiet and undriven.
  property p_rst;
    $fell(SYS_RST) |-> &MODULE_IO_OE_N && MODULE_IO_OUT == '0 && !IRQ
      && !WDT_RST_REQ && PRDATA == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset state");
  // A match fires once; the counter needs ticks before any other match.
  property p_wdt; WDT_RST_REQ |=> !WDT_RST_REQ [*3]; endproperty
  a_wdt: assert property (p_wdt) else $error("reset request too long");
  // Pin drive follows the mode bits, which only a bus write changes.
  property p_drive; !(acc && PWRITE) |=> $stable(MODULE_IO_OE_N); endproperty
  a_drive: assert property (p_drive) else $error("drive moved alone");
  c_wdt: cover property (WDT_RST_REQ);
  c_irq: cover property ($rose(IRQ));
  c_pin: cover property ($changed(MODULE_IO_OUT));
endmodule

bind pcw_top pcw_chk i_pcw_chk (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .T0_OVF(T0_OVF),
  .EXT_CLK_IN(EXT_CLK_IN), .MODULE_IO_OUT(MODULE_IO_OUT),
  .MODULE_IO_OE_N(MODULE_IO_OE_N), .IRQ(IRQ), .WDT_RST_REQ(WDT_RST_REQ)
);

// ### test/pcw_pins_model.sv
// Far side of the array: port pins with pull-ups, timer 0 overflow and
// an external count input. Assumes the same core clock as the array.
module pcw_pins_model
  import pcw_pkg::*;
(
  input wire logic clk,
  input wire logic [NUM_MOD-1:0] out,
  input wire logic [NUM_MOD-1:0] oe_n,
  output logic [NUM_MOD-1:0] pin,
  output logic t0_ovf,
  output logic ext_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 0;
  // A released pin is pulled up, so a stale level can never pass.
  assign pin = (out & ~oe_n) | oe_n;
  initial begin
    t0_ovf = 1'b0;
    ext_clk = 1'b0;
  end
  // Overflow every 10 cycles, external edge every 16 cycles.
  always @(posedge clk) begin
    n <= (n + 1) % 80;
    t0_ovf <= (n % 10) == 9;
    ext_clk <= (n % 16) >= 8;
  end
endmodule

// ### test/test_pca_compare_pwm_watchdog.sv
// Self-checking bench for the compare array, acting as firmware on APB.
// Assumes pcw_top, the pins model and the bound checker.
module test_pca_compare_pwm_watchdog
  import pcw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, t0, ext, irq, wdt, err, hit;
  logic [4:0] out, oe_n, pin;
  logic [6:0] obs;
  logic [7:0] d;
  int miscompares = 0, tests_run = 0, n;
  assign obs = {wdt, irq, pin};

  pcw_top i_pcw_top (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .T0_OVF(t0),
    .EXT_CLK_IN(ext), .MODULE_IO_OUT(out), .MODULE_IO_OE_N(oe_n),
    .IRQ(irq), .WDT_RST_REQ(wdt));
  pcw_pins_model i_pcw_pins_model (.clk(clk), .out(out), .oe_n(oe_n),
    .pin(pin), .t0_ovf(t0), .ext_clk(ext));

  // Free-running core clock, 8 ns period.
  initial forever #4 clk = ~clk;

  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One APB transfer; an idle cycle after it keeps drives one per step.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] v);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_bit(input int s, input logic v, input int lim);
    hit = 1'b0;
    for (int k = 0; k < lim && !hit; k++) begin
      @(posedge clk);
      hit = obs[s] === v;
    end
  endtask

  // Stop, park the counter just below the wrap, pick source, restart.
  task automatic rerun(input logic [31:0] cm);
    wr(ADDR_CTRL, 32'h00);
    wr(ADDR_CNT_LO, 32'hF0);
    wr(ADDR_CNT_HI, 32'hFF);
    wr(ADDR_PCA_MODE, cm);
    wr(ADDR_CTRL, 32'h40);
  endtask

  function automatic logic [7:0] at(input logic [7:0] b, input int i);
    return b + 8'(4 * i);
  endfunction

  function automatic int pwm_high(input logic [7:0] v);
    return (256 - v) * int'(DIV_FAST);
  endfunction

  function automatic logic near(input logic [7:0] g, input int s);
    int e;
    e = s == 0 ? 480 / int'(DIV_SLOW) : s == 1 ? 480 / int'(DIV_FAST)
      : s == 2 ? 48 : 30;
    return int'(g) >= e - 3 && int'(g) <= e + 3;
  endfunction

  // Hang guard sized well beyond the whole sequence.
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    void'($urandom(52));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Modes and high compare bytes start cleared; a hole reads zero.
    for (int i = 0; i < NUM_MOD; i++) begin
      rd(at(ADDR_MODE_BASE, i));
      chk("mode", 32'h0, q);
      rd(at(ADDR_CMPH_BASE, i));
      chk("cmph", 32'h0, q);
    end
    rd(8'h7C);
    chk("hole", 32'h1, q | 32'(err));
    // Module 0 flips, module 1 flags and interrupts, module 2 stays suspended.
    wr(at(ADDR_MODE_BASE, 0), 32'h4C);
    wr(at(ADDR_MODE_BASE, 1), 32'h49);
    wr(at(ADDR_MODE_BASE, 2), 32'h48);
    for (int i = 0; i < 3; i++) wr(at(ADDR_CMPL_BASE, i), 32'h03);
    for (int i = 0; i < 2; i++) wr(at(ADDR_CMPH_BASE, i), 32'h00);
    rerun(32'h02);
    wait_bit(0, 1'b1, 200);
    chk("hso pin", 32'h1, 32'(hit));
    wait_bit(5, 1'b1, 8);
    chk("irq", 32'h1, 32'(hit));
    rd(ADDR_CTRL);
    chk("flags", 32'h43, q);
    // Pin 0 has flipped high; module 2 still shows as suspended.
    rd(ADDR_STATUS);
    chk("status", 32'h1B01, q);
    chk("drive", 32'h1E, 32'(oe_n));
    // Resuming module 2 and re-crossing the wrap toggles again.
    wr(at(ADDR_CMPH_BASE, 2), 32'h00);
    rerun(32'h02);
    chk("irq off", 32'h0, 32'(irq));
    wait_bit(0, 1'b0, 200);
    chk("hso again", 32'h1, 32'(hit));
    rd(ADDR_CTRL);
    chk("flags", 32'h47, q);
    // Watchdog armed in order; then its enable is cleared ahead.
    wr(at(ADDR_MODE_BASE, 4), 32'h4C);
    wr(at(ADDR_CMPL_BASE, 4), 32'h03);
    wr(at(ADDR_CMPH_BASE, 4), 32'h00);
    rerun(32'h42);
    wait_bit(6, 1'b1, 200);
    chk("wdt", 32'h1, 32'(hit));
    chk("m4 drive", 32'h0, 32'(oe_n[4]));
    rerun(32'h02);
    wait_bit(6, 1'b1, 200);
    chk("wdt off", 32'h0, 32'(hit));
    // Re-armed, then kept quiet by moving the compare value away.
    rerun(32'h42);
    wr(at(ADDR_CMPL_BASE, 4), 32'h00);
    wr(at(ADDR_CMPH_BASE, 4), 32'h80);
    wait_bit(6, 1'b1, 200);
    chk("wdt kept", 32'h0, 32'(hit));
    // Duty sweep on module 3: corners, then random values.
    wr(at(ADDR_MODE_BASE, 3), 32'h42);
    for (int k = 0; k < 4; k++) begin
      d = k == 0 ? 8'h00 : k == 1 ? 8'hFF : 8'($urandom_range(1, 254));
      wr(at(ADDR_CMPH_BASE, 3), 32'(d));
      repeat (1100) @(posedge clk);
      rd(at(ADDR_CMPL_BASE, 3));
      chk("copy", 32'(d), q);
      n = 0;
      repeat (1024) begin
        @(posedge clk);
        n += int'(pin[3]);
      end
      chk("pwm high", 32'(pwm_high(d)), 32'(n));
    end
    // Count over a fixed span on every clock source.
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CTRL, 32'h00);
      wr(ADDR_CNT_LO, 32'h00);
      wr(ADDR_CNT_HI, 32'h00);
      wr(ADDR_PCA_MODE, 32'(s * 2));
      wr(ADDR_CTRL, 32'h40);
      repeat (480) @(posedge clk);
      wr(ADDR_CTRL, 32'h00);
      rd(ADDR_CNT_LO);
      chk("count", 32'h1, 32'(near(q[7:0], s)));
    end
    close_out();
  end
endmodule
